//--- homing_pkg.sv
// homing_pkg: constants, codes and carrier types of the homing method selector
// assumes: single clock domain at 100 MHz, shared by the selector and its register port
`default_nettype none

package homing_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int POS_W  = 32;                 // position width
   localparam int VEL_W  = 16;                 // velocity width
   localparam int NUM_IN = 7;                  // general digital inputs

   // ---------------------------------------------------------------
   // register offsets (byte addresses, register index = byte address / 4)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_METHOD   = 8'h00; // method selector
   localparam logic [7:0] REG_OFFSET   = 8'h04; // zero offset value
   localparam logic [7:0] REG_FSEL0    = 8'h08; // input function select, input 0..6 at +4 each
   localparam logic [7:0] REG_VSWITCH  = 8'h24; // switch search velocity
   localparam logic [7:0] REG_VZERO    = 8'h28; // zero search velocity
   localparam logic [7:0] REG_CONTROL  = 8'h2c; // bit11 start homing
   localparam logic [7:0] REG_STATUS   = 8'h30; // status bits
   localparam logic [7:0] REG_POSITION = 8'h34; // reported position

   // ---------------------------------------------------------------
   // input function codes and control bit
   // ---------------------------------------------------------------
   localparam logic [3:0] FSEL_POS_LIMIT = 4'h5;  // positive limit switch
   localparam logic [3:0] FSEL_NEG_LIMIT = 4'h6;  // negative limit switch
   localparam logic [3:0] FSEL_CAM       = 4'ha;  // homing cam
   localparam int         START_BIT      = 11;    // start bit in the control word

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic signed [7:0] METHOD_RST = 8'sh00;
   localparam logic [VEL_W-1:0]  VEL_RST    = 16'h0000;

   // ---------------------------------------------------------------
   // method codes
   // ---------------------------------------------------------------
   localparam logic signed [7:0] M_INC_POS  = -8'sd7;
   localparam logic signed [7:0] M_INC_NEG  = -8'sd6;
   localparam logic signed [7:0] M_ABS      = -8'sd5;
   localparam logic signed [7:0] M_CONT_FAL = -8'sd4;
   localparam logic signed [7:0] M_CONT_RIS = -8'sd3;
   localparam logic signed [7:0] M_NONE     = -8'sd2;
   localparam logic signed [7:0] M_ZERO     = -8'sd1;
   localparam logic signed [7:0] M_HERE     = 8'sd35;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_SEARCH, ST_APPROACH, ST_INDEX, ST_DONE
   } homeState_t;

   // decoded strategy of one method code
   typedef struct packed {
      logic run;       // movement needed
      logic useLimit;  // search a limit switch
      logic useCam;    // search a cam edge
      logic useIndex;  // zero taken at a zero pulse
      logic dirPos;    // search direction positive
      logic risingEdge;// cam edge polarity
      logic instant;   // set position without movement
      logic zeroPos;   // instant: clear position before the offset
   } methodInfo_t;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } regReq_t;

   // motion command towards the profile generator
   typedef struct packed {
      logic             move;
      logic             dirPos;
      logic [VEL_W-1:0] vel;
   } motionCmd_t;

endpackage : homing_pkg

`default_nettype wire

//--- homing_method_selector.sv
// homing_method_selector: decodes a signed method code and sequences homing
// assumes: switch and encoder inputs come from pins; position from an encoder on mclk
//
// Decided for this implementation: the register offsets and strobed register access.
`default_nettype none
`timescale 1ns/1ps

// Function
// - cam routable from any of seven inputs
// - input codes 5,6,10 mark limits, cam
// - strategy chosen by signed method code
// - codes -7/-6 distance-coded, positive/negative search
// - code -5: absolute position plus offset
// - absolute homing at power-on, stage off allowed
// - repeated absolute homing keeps position
// - codes -4/-3 cam continuous, treated undefined
// - code -2: only add offset
// - code -2: done at first stage on
// - code -1: position zero, then offset
// - codes 1/2 limit switch plus zero pulse
// - codes 3..6 cam edge plus zero pulse
// - codes 17/18 limit switch, no pulse
// - codes 19..22 cam edge, no pulse
// - codes 33/34 next zero pulse neg/pos
// - code 35: present position becomes reference
// - search speed first, approach speed second
// - index evaluation runs only while needed
module homing_method_selector
   import homing_pkg::*;
#(
   parameter int NIN = homing_pkg::NUM_IN     // number of digital inputs
) (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rstn,
   // register port
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   input  wire logic [7:0]                    regAddr,
   input  wire logic [31:0]                   regWdata,
   output logic      [31:0]                   regRdata,
   // pins and encoder
   input  wire logic [NIN-1:0]                digitalIn,
   input  wire logic                          indexPulse,
   input  wire logic [homing_pkg::POS_W-1:0]  encoderPos,
   input  wire logic                          powerStageOn,
   // motion and status
   output homing_pkg::motionCmd_t             motion,
   output logic                               indexEnable,
   output logic                               homingDone,
   output logic      [homing_pkg::POS_W-1:0]  actualPos
);
   import homing_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic signed [7:0]       method;    // method selector
      logic [POS_W-1:0]        offset;    // zero offset value
      logic [NIN-1:0][3:0]     fsel;      // input function select
      logic [VEL_W-1:0]        vSwitch;   // switch search velocity
      logic [VEL_W-1:0]        vZero;     // zero search velocity
      logic [31:0]             rdata;     // read data
      homeState_t              st;        // sequencer state
      logic [POS_W-1:0]        pos;       // reported position
      logic                    relOrigin; // origin relative to encoder
      logic [POS_W-1:0]        base;      // encoder value at zero
      logic                    done;      // homing completed
      logic                    stagePrev; // last power stage level
      logic                    powerUp;   // power-on homing still pending
      logic                    camPrev;   // last cam level
      logic                    idxPrev;   // last index level
      logic [NIN-1:0]          in1;       // synchroniser stage 1
      logic [NIN-1:0]          in2;       // synchroniser stage 2
      logic [2:0]              ctl1;      // index, stage stage 1
      logic [2:0]              ctl2;      // stage 2
      motionCmd_t              mot;
      logic                    idxEn;
   } state_t;

   state_t stQ, stD;

   // ---------------------------------------------------------------
   // method decode
   // ---------------------------------------------------------------
   function automatic methodInfo_t decodeMethod(input logic signed [7:0] m);
      methodInfo_t i;
      i = '0;
      if (m == M_INC_POS || m == M_INC_NEG) begin
         i.run = 1'b1; i.useIndex = 1'b1; i.dirPos = (m == M_INC_POS);
      end else if (m == M_ABS || m == M_NONE) begin
         i.instant = 1'b1;
      end else if (m == M_ZERO || m == M_HERE) begin
         i.instant = 1'b1; i.zeroPos = 1'b1;
      end else if (m == 8'sd1 || m == 8'sd2 || m == 8'sd17 || m == 8'sd18) begin
         i.run = 1'b1; i.useLimit = 1'b1;
         i.dirPos = (m == 8'sd2 || m == 8'sd18);
         i.useIndex = (m < 8'sd17);
      end else if ((m >= 8'sd3 && m <= 8'sd6) || (m >= 8'sd19 && m <= 8'sd22)) begin
         i.run = 1'b1; i.useCam = 1'b1;
         i.useIndex = (m <= 8'sd6);
         i.dirPos = (m == 8'sd3 || m == 8'sd4 || m == 8'sd19 || m == 8'sd20);
         i.risingEdge = m[0] == 1'b0;
      end else if (m == 8'sd33 || m == 8'sd34) begin
         i.run = 1'b1; i.useIndex = 1'b1; i.dirPos = (m == 8'sd34);
      end
      // codes -4/-3, 0, 7..16, 23..32 stay all zero: no run
      return i;
   endfunction

   // whether any input carrying a given function is high
   function automatic logic anyFunc(input logic [NIN-1:0][3:0] f,
                                    input logic [NIN-1:0] lv, input logic [3:0] code);
      logic r;
      r = 1'b0;
      for (int k = 0; k < NIN; k++) begin
         if (f[k] == code && lv[k]) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction

   methodInfo_t mi;
   logic        camLvl, posLim, negLim, idxSync, stageSync, startReq, hit;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      stD       = stQ;
      mi        = decodeMethod(stQ.method);
      camLvl    = anyFunc(stQ.fsel, stQ.in2, FSEL_CAM);
      posLim    = anyFunc(stQ.fsel, stQ.in2, FSEL_POS_LIMIT);
      negLim    = anyFunc(stQ.fsel, stQ.in2, FSEL_NEG_LIMIT);
      idxSync   = stQ.ctl2[0];
      stageSync = stQ.ctl2[1];
      startReq  = 1'b0;
      hit       = 1'b0;
      // synchronisers
      stD.in1   = digitalIn;
      stD.in2   = stQ.in1;
      stD.ctl1  = {1'b0, powerStageOn, indexPulse};
      stD.ctl2  = stQ.ctl1;
      stD.camPrev   = camLvl;
      stD.idxPrev   = idxSync;
      stD.stagePrev = stageSync;
      // register writes
      if (regWr) begin
         if (regAddr == REG_METHOD) begin
            stD.method = regWdata[7:0];
         end else if (regAddr == REG_OFFSET) begin
            stD.offset = regWdata;
         end else if (regAddr == REG_VSWITCH) begin
            stD.vSwitch = regWdata[VEL_W-1:0];
         end else if (regAddr == REG_VZERO) begin
            stD.vZero = regWdata[VEL_W-1:0];
         end else if (regAddr == REG_CONTROL) begin
            startReq    = regWdata[START_BIT];
            stD.powerUp = 1'b0;                             // a command ends the power-on phase
         end else if (regAddr >= REG_FSEL0 && regAddr < REG_VSWITCH
                      && regAddr[1:0] == 2'b00) begin
            stD.fsel[3'((regAddr - REG_FSEL0) >> 2)] = regWdata[3:0];
         end
      end
      // register reads, data valid one cycle later
      stD.rdata = 32'h0000_0000;
      if (regRd) begin
         if (regAddr == REG_METHOD) begin
            stD.rdata = {{24{stQ.method[7]}}, stQ.method};
         end else if (regAddr == REG_OFFSET) begin
            stD.rdata = stQ.offset;
         end else if (regAddr == REG_VSWITCH) begin
            stD.rdata = {16'h0000, stQ.vSwitch};
         end else if (regAddr == REG_VZERO) begin
            stD.rdata = {16'h0000, stQ.vZero};
         end else if (regAddr == REG_STATUS) begin
            stD.rdata = {26'h0, stQ.idxEn, stQ.mot.move, camLvl, negLim, posLim, stQ.done};
         end else if (regAddr == REG_POSITION) begin
            stD.rdata = stQ.pos;
         end else if (regAddr >= REG_FSEL0 && regAddr < REG_VSWITCH
                      && regAddr[1:0] == 2'b00) begin
            stD.rdata = {28'h0, stQ.fsel[3'((regAddr - REG_FSEL0) >> 2)]};
         end
      end
      // power-on absolute homing needs no power stage and no command: the request stays
      // pending from reset until the first control write, and fires once the method holds -5, so
      // a configuration loaded after power-on still homes by itself
      if (stQ.powerUp && stQ.method == M_ABS) begin
         stD.powerUp = 1'b0;
         startReq    = 1'b1;
      end
      // first switch-on of the stage with code -2
      if (stQ.method == M_NONE && stageSync && !stQ.stagePrev && !stQ.done) begin
         startReq = 1'b1;
      end
      // reported position follows the encoder against the origin
      stD.pos = stQ.relOrigin ? encoderPos - stQ.base + stQ.offset : stQ.pos;
      // sequencer
      case (stQ.st)
         ST_IDLE, ST_DONE: begin
            if (startReq) begin
               stD.done = 1'b0;
               if (mi.instant) begin
                  stD.relOrigin = 1'b1;
                  stD.base      = mi.zeroPos ? encoderPos : {POS_W{1'b0}};
                  stD.pos       = mi.zeroPos ? stQ.offset : encoderPos + stQ.offset;
                  stD.done      = 1'b1;
                  stD.st        = ST_DONE;
               end else if (mi.run) begin
                  stD.st = (mi.useLimit || mi.useCam) ? ST_SEARCH : ST_INDEX;
               end else begin
                  stD.st = ST_IDLE;
               end
            end
         end
         ST_SEARCH: begin
            // hit the switch or the chosen cam edge
            if (mi.useLimit) begin
               hit = mi.dirPos ? posLim : negLim;
            end else begin
               hit = mi.risingEdge ? (camLvl && !stQ.camPrev) : (!camLvl && stQ.camPrev);
            end
            if (hit) begin
               stD.st = mi.useIndex ? ST_INDEX : ST_APPROACH;
            end
         end
         ST_APPROACH, ST_INDEX: begin
            // zero at the switch point, or at the next zero pulse
            if (stQ.st == ST_APPROACH || (idxSync && !stQ.idxPrev)) begin
               stD.relOrigin = 1'b1;
               stD.base      = encoderPos;
               stD.pos       = stQ.offset;
               stD.done      = 1'b1;
               stD.st        = ST_DONE;
            end
         end
         default: stD.st = ST_IDLE;
      endcase
      // motion command towards the profile generator
      stD.mot.move   = (stD.st == ST_SEARCH) || (stD.st == ST_INDEX);
      // after a switch or cam the zero pulse is sought on the way back; pure zero-pulse
      // and distance-coded methods keep their own direction
      stD.mot.dirPos = (stD.st == ST_SEARCH) ? mi.dirPos
                                             : mi.dirPos ^ (mi.useLimit || mi.useCam);
      stD.mot.vel    = (stD.st == ST_SEARCH && (mi.useLimit || mi.useCam)) ? stQ.vSwitch : stQ.vZero;
      stD.idxEn      = (stD.st == ST_INDEX) && mi.useIndex;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stQ         <= '0;
         stQ.method  <= METHOD_RST;
         stQ.vSwitch <= VEL_RST;
         stQ.vZero   <= VEL_RST;
         stQ.st      <= ST_IDLE;
         stQ.powerUp <= 1'b1;
      end else begin
         stQ <= stD;
      end
   end

   // outputs straight from flip-flops
   assign regRdata    = stQ.rdata;
   assign motion      = stQ.mot;
   assign indexEnable = stQ.idxEn;
   assign homingDone  = stQ.done;
   assign actualPos   = stQ.pos;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // index evaluation only while a zero pulse is sought, and off once homed
   idx_only_homing_a: assert property (stQ.idxEn |-> stQ.st == ST_INDEX && !stQ.done)
      else $error("index evaluation outside index search");
   // reserved codes neither move the axis nor touch the reported position
   undef_no_run_a: assert property (
      (stQ.st == ST_IDLE || stQ.st == ST_DONE) && startReq && !mi.run && !mi.instant
      |=> stQ.st == ST_IDLE && !stQ.mot.move && $stable(stQ.pos))
      else $error("undefined method moved or changed position");
   // the switch or cam search runs at the first speed
   search_speed_a: assert property (
      stQ.st == ST_SEARCH && stQ.mot.move && $stable(stQ.vSwitch)
      |-> stQ.mot.vel == stQ.vSwitch)
      else $error("search not at switch velocity");
   // the zero pulse search runs at the second speed
   index_speed_a: assert property (
      stQ.st == ST_INDEX && $stable(stQ.vZero) |-> stQ.mot.vel == stQ.vZero)
      else $error("zero pulse search not at zero velocity");
   // pure zero-pulse and distance-coded methods keep their own direction
   index_dir_a: assert property (
      stQ.st == ST_INDEX && !(mi.useLimit || mi.useCam) && $stable(stQ.method)
      |-> stQ.mot.dirPos == mi.dirPos)
      else $error("zero pulse search in wrong direction");
   // codes -1 and 35 place the reference at the offset at once
   zero_set_a: assert property (
      (stQ.st == ST_IDLE || stQ.st == ST_DONE) && startReq
      && (stQ.method == M_ZERO || stQ.method == M_HERE)
      |=> stQ.done && stQ.pos == $past(stQ.offset))
      else $error("code -1 did not load offset");
   // code -5 reports encoder plus offset right after the start
   abs_pos_a: assert property (
      (stQ.st == ST_IDLE || stQ.st == ST_DONE) && startReq && stQ.method == M_ABS
      |=> stQ.pos == $past(encoderPos) + $past(stQ.offset))
      else $error("absolute position wrong");
   // code -5 homes by itself once after reset, with no stage and no command
   abs_power_on_a: assert property (
      stQ.powerUp && stQ.method == M_ABS && stQ.st == ST_IDLE |=> stQ.done)
      else $error("power-on absolute homing missing");
   // code -2 completes at the first switch-on of the power stage
   stage_done_a: assert property (
      (stQ.st == ST_IDLE || stQ.st == ST_DONE) && stQ.method == M_NONE && stQ.ctl2[1]
      && !stQ.stagePrev && !stQ.done |=> stQ.done)
      else $error("code -2 not done at stage switch-on");
   // a limit switch without zero pulse ends at the switch point
   limit_hit_a: assert property (
      stQ.st == ST_SEARCH && mi.useLimit && !mi.useIndex && hit
      |=> stQ.st == ST_APPROACH ##1 stQ.done)
      else $error("limit switch homing did not complete");
   // with a zero pulse the hit hands over to the index search
   hit_to_index_a: assert property (
      stQ.st == ST_SEARCH && mi.useIndex && hit |=> stQ.st == ST_INDEX && stQ.idxEn)
      else $error("hit did not start the zero pulse search");
   // done stands until a new start
   done_hold_a: assert property (stQ.done && !startReq |=> stQ.done)
      else $error("done dropped without a new start");
   // the start bit of the master launches a run
   start_bit_a: assert property (
      regWr && regAddr == REG_CONTROL && regWdata[START_BIT]
      && stQ.st == ST_IDLE && mi.run |=> stQ.st != ST_IDLE)
      else $error("start bit ignored");

   // ---------------------------------------------------------------
   // covers of the main scenarios
   // ---------------------------------------------------------------
   cv_abs: cover property (startReq && stQ.method == M_ABS ##1 stQ.done);
   cv_cam: cover property (stQ.st == ST_SEARCH && mi.useCam ##[1:50] stQ.st == ST_INDEX);
   cv_index: cover property (stQ.st == ST_INDEX ##[1:50] stQ.done);
   cv_limit: cover property (stQ.st == ST_SEARCH && mi.useLimit
      ##[1:50] stQ.st == ST_APPROACH);
   cv_stage: cover property (stQ.method == M_NONE && stQ.ctl2[1] && !stQ.stagePrev
      ##1 stQ.done);

endmodule : homing_method_selector // homing_method_selector

`default_nettype wire

//--- axis_model.sv
// axis_model: far side of the homing selector - axis, encoder, zero pulse, one switch
// assumes: motion command on mclk; the bench picks which input carries the switch
`default_nettype none
`timescale 1ns/1ps
module axis_model
   import homing_pkg::*;
(
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rstn,
   // command side
   input  wire homing_pkg::motionCmd_t        motion,
   input  wire logic [2:0]                    selIn,
   // pins and encoder
   output logic [homing_pkg::NUM_IN-1:0]      digitalIn,
   output logic                               indexPulse,
   output logic [homing_pkg::POS_W-1:0]       encoderPos
);
   logic [POS_W-1:0] pos_q;   // axis position in counts
   logic             act;     // chosen switch active
   // -----------------------------------------------------------
   // axis: one count a cycle while a move is commanded
   // -----------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pos_q <= 32'h0000_03e8;
      end else if (motion.move) begin
         pos_q <= motion.dirPos ? pos_q + 32'h1 : pos_q - 32'h1;
      end
   end
   // switch windows on both sides of the start point, so every edge is met
   assign act        = (pos_q >= 32'h3fc && pos_q < 32'h410) ||
                       (pos_q >= 32'h3c0 && pos_q < 32'h3d4);
   // only the chosen input sees the switch, the rest stay low
   assign digitalIn  = act ? (7'h01 << selIn) : 7'h00;
   // zero pulse once every sixteen counts
   assign indexPulse = (pos_q[3:0] == 4'h0);
   assign encoderPos = pos_q;
endmodule // axis_model
`default_nettype wire

//--- tb.sv
// tb: self-checking bench of the homing method selector
// assumes: axis_model as far side; 100 MHz mclk; bus per the one-cycle strobe port
`default_nettype none
`timescale 1ns/1ps
module tb;
   import homing_pkg::*;
   logic mclk, rstn, modelRstn, regWr, regRd, indexPulse, powerStageOn, indexEnable, homingDone;
   logic [7:0]  regAddr;                 // bus address
   logic [31:0] regWdata, regRdata, rv;  // bus data, read value
   logic [6:0]  digitalIn;               // switch pins
   logic [2:0]  selIn;                   // input carrying the switch
   logic [31:0] encoderPos, actualPos, prev, exp;
   motionCmd_t  motion;                  // motion command
   int err_total, total_checks, cycles, k;
   logic sawIdx, sawVz;                  // index search / approach speed seen
   localparam logic [31:0] OFF = 32'h0000_0123;
   localparam logic [31:0] STRT = 32'h0000_0800;
   // instant and undefined codes: kind 0 enc+offset, 1 offset, 2 unchanged
   logic signed [7:0] iM [10] = '{M_ABS, M_ABS, M_NONE, M_ZERO, M_HERE,
                                  8'sd0, M_CONT_FAL, M_CONT_RIS, 8'sd15, 8'sd31};
   int iK [10] = '{0, 0, 0, 1, 1, 2, 2, 2, 2, 2};
   // moving codes: function code, input, direction, uses zero pulse
   logic signed [7:0] mM [12] = '{8'sd18, 8'sd17, 8'sd2, 8'sd1, 8'sd3, 8'sd5,
                                  8'sd19, 8'sd21, 8'sd34, 8'sd33, M_INC_POS, M_INC_NEG};
   int mF [12] = '{5, 6, 5, 6, 10, 10, 10, 10, 0, 0, 0, 0};
   int mI [12] = '{2, 1, 3, 0, 6, 4, 5, 6, 0, 0, 0, 0};
   int mD [12] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
   int mX [12] = '{0, 0, 1, 1, 1, 1, 0, 0, 1, 1, 1, 1};
   // -----------------------------------------------------------
   // instances
   // -----------------------------------------------------------
   homing_method_selector dut_u (.mclk(mclk), .rstn(rstn), .regWr(regWr), .regRd(regRd),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .digitalIn(digitalIn),
      .indexPulse(indexPulse), .encoderPos(encoderPos), .powerStageOn(powerStageOn),
      .motion(motion), .indexEnable(indexEnable), .homingDone(homingDone),
      .actualPos(actualPos));
   axis_model model_u (.mclk(mclk), .rstn(modelRstn), .motion(motion), .selIn(selIn),
      .digitalIn(digitalIn), .indexPulse(indexPulse), .encoderPos(encoderPos));
   // clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string msg);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      mclk = 0; rstn = 0; modelRstn = 0; regWr = 0; regRd = 0; regAddr = 8'h00;
      regWdata = 32'h0; powerStageOn = 0; selIn = 3'h0;
      err_total = 0; total_checks = 0; cycles = 0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1; modelRstn <= 1'b1;
      // reset values, unmapped place, control reads zero
      chk(32'(homingDone), 32'h0, "done at reset");
      rd(REG_METHOD, rv);   chk(rv, 32'h0, "method reset");
      rd(REG_STATUS, rv);   chk(rv, 32'h0, "status reset");
      rd(REG_VSWITCH, rv);  chk(rv, 32'h0, "speed reset");
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, rv);        chk(rv, 32'h0, "unmapped");
      rd(REG_CONTROL, rv);  chk(rv, 32'h0, "control reads 0");
      wr(REG_OFFSET, OFF); wr(REG_VSWITCH, 32'h0100); wr(REG_VZERO, 32'h0040);
      // instant and undefined codes, power stage off throughout
      for (int i = 0; i < 10; i++) begin
         rd(REG_POSITION, prev);
         wr(REG_METHOD, {{24{iM[i][7]}}, iM[i]});
         rd(REG_METHOD, rv);  chk(rv, {{24{iM[i][7]}}, iM[i]}, "method");
         if (i == 0) chk(32'(homingDone), 32'h1, "power-on homing");
         wr(REG_CONTROL, STRT);
         repeat (4) @(posedge mclk);
         #1 exp = (iK[i] == 0) ? encoderPos + OFF : (iK[i] == 1) ? OFF : prev;
         chk(actualPos, exp, "instant pos");
         if (iK[i] < 2) chk(32'(homingDone), 32'h1, "instant done");
         chk(32'(motion.move), 32'h0, "no move");
      end
      // moving codes through the far-side model
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk) modelRstn <= 1'b0;
         @(posedge mclk) modelRstn <= 1'b1;
         for (int j = 0; j < 7; j++) wr(REG_FSEL0 + 8'(4 * j), 32'h0);
         wr(REG_FSEL0 + 8'(4 * mI[i]), 32'(mF[i]));
         selIn <= 3'(mI[i]);
         wr(REG_METHOD, {{24{mM[i][7]}}, mM[i]});
         wr(REG_CONTROL, STRT);
         #1 chk(32'(motion.move), 32'h1, "move");
         chk(32'(motion.dirPos), 32'(mD[i]), "dir");
         if (mF[i] != 0) chk(32'(motion.vel), 32'h0100, "search speed");
         sawIdx = 0; sawVz = 0;
         for (k = 0; k < 800 && homingDone !== 1'b1; k++) begin
            @(posedge mclk);
            #1 sawIdx |= (indexEnable === 1'b1);
            sawVz |= (motion.move === 1'b1 && motion.vel === 16'h0040);
         end
         chk(32'(homingDone), 32'h1, "moving done");
         chk(32'(indexEnable), 32'h0, "index off");
         chk(32'(motion.move), 32'h0, "stopped");
         if (mX[i] != 0) chk(32'(sawIdx), 32'h1, "index on");
         if (mX[i] != 0 && mF[i] != 0) chk(32'(sawVz), 32'h1, "zero speed");
         if (mX[i] == 0) chk(actualPos, OFF, "approach pos");
      end
      // second reset, then code -2 completes at first power stage switch-on
      @(posedge mclk) rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      #1 chk(32'(homingDone), 32'h0, "done cleared");
      wr(REG_METHOD, {{24{M_NONE[7]}}, M_NONE});
      repeat (3) @(posedge mclk);
      #1 chk(32'(homingDone), 32'h0, "done waits stage");
      powerStageOn <= 1'b1;
      for (k = 0; k < 8 && homingDone !== 1'b1; k++) @(posedge mclk);
      #1 chk(32'(homingDone), 32'h1, "done at stage on");
      chk(actualPos, encoderPos, "code -2 position");
      wrap_up();
   end
endmodule // tb
`default_nettype wire
